// >>> shared/ddru_defs.svh
`ifndef DDRU_DEFS_SVH
`define DDRU_DEFS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define DDRU_OFF_CTRL   32'h0000_0000
`define DDRU_OFF_STAT   32'h0000_0004
`define DDRU_OFF_MODE   32'h0000_0008
`define DDRU_OFF_CCNT   32'h0000_000c

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define DDRU_CTRL_RANK2 0
`define DDRU_CTRL_RST   1'h0
`define DDRU_MR_RST     14'h0042
`define DDRU_MR_BT      3
`define DDRU_MR_BL_HI   2
`define DDRU_MR_CL_HI   6
`define DDRU_MR_CL_LO   4
`define DDRU_MR_BL8     3'h3
`define DDRU_AP_BIT     10
`define DDRU_ROW_W      13
`define DDRU_COL_W      10
`define DDRU_MEM_AW     6

`endif

// >>> shared/ddru_pkg.sv
package ddru_pkg;

	// burst engine, gray along idle -> read -> write
	typedef enum logic [1:0]
	{
		DDRU_BST_IDLE = 2'h0,
		DDRU_BST_RD   = 2'h1,
		DDRU_BST_WR   = 2'h3
	} ddru_bst_e;

	typedef enum logic [1:0]
	{
		DDRU_PWR_ACT  = 2'h0,
		DDRU_PWR_PDN  = 2'h1,
		DDRU_PWR_SELF = 2'h3
	} ddru_pwr_e;

	// {row strobe, column strobe, write strobe}, all low active
	typedef enum logic [2:0]
	{
		DDRU_CMD_MRS = 3'h0,
		DDRU_CMD_REF = 3'h1,
		DDRU_CMD_PRE = 3'h2,
		DDRU_CMD_ACT = 3'h3,
		DDRU_CMD_WR  = 3'h4,
		DDRU_CMD_RD  = 3'h5,
		DDRU_CMD_RSV = 3'h6,
		DDRU_CMD_NOP = 3'h7
	} ddru_cmd_e;

endpackage : ddru_pkg

// >>> rtl/ddru_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddru_defs.svh"

module ddru_mem (
	// clock and reset
	input  wire logic                    clk_sys_in,
	input  wire logic                    arst_n_in,
	// write port with byte enables
	input  wire logic                    wr_en_in,
	input  wire logic [`DDRU_MEM_AW-1:0] wr_addr_in,
	input  wire logic [7:0]              wr_be_in,
	input  wire logic [63:0]             wr_data_in,
	// read port, data one cycle later
	input  wire logic [`DDRU_MEM_AW-1:0] rd_addr_in,
	output logic      [63:0]             rd_data_out
);

	logic [63:0] mem_r [2**`DDRU_MEM_AW];

	always_ff @(posedge clk_sys_in)
	begin
		for (int b = 0; b < 8; b++)
		begin
			if (wr_en_in && wr_be_in[b])
				mem_r[wr_addr_in][b*8 +: 8] <= wr_data_in[b*8 +: 8];
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			rd_data_out <= 64'h0;
		else
			rd_data_out <= mem_r[rd_addr_in];
	end

endmodule : ddru_mem

`default_nettype wire

// >>> rtl/ddru_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddru_defs.svh"

// Notes on behaviour
// - command and address pins are taken on the rising clock edge only.
// - clock enable low enters power-down, or self refresh on refresh.
// - deselected rank ignores new commands; running bursts carry on.
// - activate opens the row given by the address in the addressed bank.
// - read or write uses the ten low address bits as column.
// - auto-precharge bit on read/write closes the bank after the burst.
// - precharge with that bit high closes all four banks, else one.
// - mask high blocks a write data byte; masks ignored on reads.
// - second clock enable and termination reach the second rank only.
// - thirteen row bits and ten column bits are decoded.
// - strobe has one-cycle preamble and a postamble around data.

module ddru_top (
	// clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        arst_n_in,
	// ahb-lite register slave
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	// command and address
	input  wire logic [1:0]  ck_en_in,
	input  wire logic [1:0]  cs_n_in,
	input  wire logic        ras_n_in,
	input  wire logic        cas_n_in,
	input  wire logic        we_n_in,
	input  wire logic [1:0]  ba_in,
	input  wire logic [13:0] addr_in,
	input  wire logic [1:0]  odt_in,
	// data
	input  wire logic [7:0]  dm_in,
	input  wire logic [63:0] dq_in,
	output logic      [63:0] dq_out,
	output logic             dq_oe_out,
	output logic             dqs_out,
	output logic             dqs_oe_out,
	output logic      [1:0]  odt_on_out
);

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	ddru_pkg::ddru_cmd_e cmd;
	ddru_pkg::ddru_pwr_e pwr_r [2];
	ddru_pkg::ddru_bst_e st_r;
	logic                ctrl_rank2_r;
	logic [13:0]         mr_r;
	logic [15:0]         cmd_cnt_r;
	logic [1:0]          rank_ok;
	logic                sel;
	logic                go;
	logic [2:0]          idx;
	logic                rw_go;
	logic                is_rd;
	logic [7:0]          open_r;
	logic [`DDRU_ROW_W-1:0] row_r [8];

	assign cmd = ddru_pkg::ddru_cmd_e'({ras_n_in, cas_n_in, we_n_in});

	// a rank listens only when selected, clocked and awake
	always_comb
	begin
		for (int r = 0; r < 2; r++)
			rank_ok[r] = !cs_n_in[r] && ck_en_in[r] &&
				(pwr_r[r] == ddru_pkg::DDRU_PWR_ACT) &&
				(r == 0 || ctrl_rank2_r);
	end

	assign sel   = !rank_ok[0];
	assign go    = (|rank_ok) && (cmd != ddru_pkg::DDRU_CMD_NOP);
	assign idx   = {sel, ba_in};
	assign is_rd = (cmd == ddru_pkg::DDRU_CMD_RD);
	// one burst at a time; a burst to a closed bank is dropped
	assign rw_go = go && (is_rd || cmd == ddru_pkg::DDRU_CMD_WR) &&
		(st_r == ddru_pkg::DDRU_BST_IDLE) && open_r[idx];

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			cmd_cnt_r <= 16'h0;
		else if (go)
			cmd_cnt_r <= cmd_cnt_r + 16'h1;
	end

	// one mode register shared by both ranks; extended sets ignored
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			mr_r <= `DDRU_MR_RST;
		else if (go && cmd == ddru_pkg::DDRU_CMD_MRS && ba_in == 2'h0)
			mr_r <= addr_in;
	end

	// ----------------------------------------------------------------
	// power state per rank
	// ----------------------------------------------------------------
	for (genvar r = 0; r < 2; r++)
	begin : g_rank
		always_ff @(posedge clk_sys_in or negedge arst_n_in)
		begin
			if (!arst_n_in)
				pwr_r[r] <= ddru_pkg::DDRU_PWR_ACT;
			else if (ck_en_in[r])
				pwr_r[r] <= ddru_pkg::DDRU_PWR_ACT;
			else if (pwr_r[r] == ddru_pkg::DDRU_PWR_ACT)
				pwr_r[r] <= (!cs_n_in[r] && cmd == ddru_pkg::DDRU_CMD_REF) ?
					ddru_pkg::DDRU_PWR_SELF : ddru_pkg::DDRU_PWR_PDN;
		end

		always_ff @(posedge clk_sys_in or negedge arst_n_in)
		begin
			if (!arst_n_in)
				odt_on_out[r] <= 1'b0;
			else
				odt_on_out[r] <= odt_in[r] && ck_en_in[r] &&
					(r == 0 || ctrl_rank2_r);
		end
	end

	// ----------------------------------------------------------------
	// burst engine
	// ----------------------------------------------------------------
	logic [9:0] col_r;
	logic [2:0] bidx_r;
	logic       ap_r;
	logic [4:0] cnt_r;
	logic [4:0] cl;
	logic [4:0] bl;
	logic       bl8;
	logic [4:0] beat;
	logic       rd_mem_win;
	logic       rd_dat_win;
	logic       wr_win;
	logic       last;
	logic       mem_we;
	logic [7:0] mem_be;
	logic [63:0] mem_rd;
	logic [`DDRU_MEM_AW-1:0] mem_addr;

	assign bl8 = (mr_r[`DDRU_MR_BL_HI:0] == `DDRU_MR_BL8);
	assign cl  = {2'h0, mr_r[`DDRU_MR_CL_HI:`DDRU_MR_CL_LO]};
	assign bl  = bl8 ? 5'h8 : 5'h4;

	// reads fetch two cycles ahead: memory register, then pin register
	assign rd_mem_win = (st_r == ddru_pkg::DDRU_BST_RD) &&
		(cnt_r >= cl - 5'h2) && (cnt_r < cl - 5'h2 + bl);
	assign rd_dat_win = (st_r == ddru_pkg::DDRU_BST_RD) &&
		(cnt_r >= cl - 5'h1) && (cnt_r < cl - 5'h1 + bl);
	// write latency is column latency less one
	assign wr_win = (st_r == ddru_pkg::DDRU_BST_WR) &&
		(cnt_r >= cl - 5'h1) && (cnt_r < cl - 5'h1 + bl);
	assign beat = (st_r == ddru_pkg::DDRU_BST_RD) ?
		cnt_r - (cl - 5'h2) : cnt_r - (cl - 5'h1);
	// reads end after the postamble, writes with the last beat
	assign last = (st_r == ddru_pkg::DDRU_BST_RD) ?
		(cnt_r == cl + bl) : (cnt_r == cl + bl - 5'h2);

	function automatic logic [`DDRU_MEM_AW-1:0] beat_addr(
		input logic [1:0] ba,
		input logic [9:0] col,
		input logic [2:0] bt,
		input logic       ilv,
		input logic       b8
	);
		logic [2:0] lo;
		lo = ilv ? (col[2:0] ^ bt) : (col[2:0] + bt);
		beat_addr = b8 ? {ba, col[3], lo} : {ba, col[3], col[2], lo[1:0]};
	endfunction : beat_addr

	assign mem_addr = beat_addr(bidx_r[1:0], col_r, beat[2:0],
		mr_r[`DDRU_MR_BT], bl8);
	assign mem_we = wr_win;
	assign mem_be = ~dm_in;

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			st_r   <= ddru_pkg::DDRU_BST_IDLE;
			cnt_r  <= 5'h0;
			col_r  <= 10'h0;
			bidx_r <= 3'h0;
			ap_r   <= 1'b0;
		end
		else if (rw_go)
		begin
			st_r   <= is_rd ? ddru_pkg::DDRU_BST_RD : ddru_pkg::DDRU_BST_WR;
			cnt_r  <= 5'h1;
			col_r  <= addr_in[`DDRU_COL_W-1:0];
			bidx_r <= idx;
			ap_r   <= addr_in[`DDRU_AP_BIT];
		end
		else if (st_r != ddru_pkg::DDRU_BST_IDLE)
		begin
			cnt_r <= cnt_r + 5'h1;
			if (last)
				st_r <= ddru_pkg::DDRU_BST_IDLE;
		end
	end

	// ----------------------------------------------------------------
	// bank state
	// ----------------------------------------------------------------
	for (genvar i = 0; i < 8; i++)
	begin : g_bank
		always_ff @(posedge clk_sys_in or negedge arst_n_in)
		begin
			if (!arst_n_in)
			begin
				open_r[i] <= 1'b0;
				row_r[i]  <= '0;
			end
			else if (go && cmd == ddru_pkg::DDRU_CMD_ACT && idx == i)
			begin
				open_r[i] <= 1'b1;
				row_r[i]  <= addr_in[`DDRU_ROW_W-1:0];
			end
			else if (go && cmd == ddru_pkg::DDRU_CMD_PRE &&
				sel == (i >= 4) &&
				(addr_in[`DDRU_AP_BIT] || ba_in == 2'(i % 4)))
				open_r[i] <= 1'b0;
			else if (st_r != ddru_pkg::DDRU_BST_IDLE && last && ap_r &&
				bidx_r == i)
				open_r[i] <= 1'b0;
		end
	end

	ddru_mem u_mem (
		.clk_sys_in  (clk_sys_in),
		.arst_n_in   (arst_n_in),
		.wr_en_in    (mem_we),
		.wr_addr_in  (mem_addr),
		.wr_be_in    (mem_be),
		.wr_data_in  (dq_in),
		.rd_addr_in  (mem_addr),
		.rd_data_out (mem_rd)
	);

	// ----------------------------------------------------------------
	// data and strobe pins
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			dq_out     <= 64'h0;
			dq_oe_out  <= 1'b0;
			dqs_out    <= 1'b0;
			dqs_oe_out <= 1'b0;
		end
		else
		begin
			if (rd_dat_win)
				dq_out <= mem_rd;
			dq_oe_out  <= rd_dat_win;
			// strobe held low through pre- and postamble
			dqs_out    <= rd_dat_win ? !dqs_out : 1'b0;
			// the last beat still showing keeps the strobe on for the postamble
			dqs_oe_out <= rd_mem_win || rd_dat_win ||
				dq_oe_out;
		end
	end

	// ----------------------------------------------------------------
	// register slave, zero wait states
	// ----------------------------------------------------------------
	logic        ahb_go;
	logic        wr_ph_r;
	logic [31:0] wad_r;
	logic [31:0] rd_val;

	assign ahb_go = hsel_in && htrans_in[1] && hready_in;

	always_comb
	begin
		case (haddr_in)
			`DDRU_OFF_CTRL: rd_val = {31'h0, ctrl_rank2_r};
			`DDRU_OFF_STAT: rd_val = {19'h0, st_r != ddru_pkg::DDRU_BST_IDLE,
				pwr_r[1], pwr_r[0], open_r};
			`DDRU_OFF_MODE: rd_val = {18'h0, mr_r};
			`DDRU_OFF_CCNT: rd_val = {16'h0, cmd_cnt_r};
			default:        rd_val = 32'h0;
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			wr_ph_r       <= 1'b0;
			wad_r         <= 32'h0;
			hrdata_out    <= 32'h0;
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
		end
		else
		begin
			wr_ph_r <= ahb_go && hwrite_in && hsize_in == 3'h2;
			if (ahb_go)
				wad_r <= haddr_in;
			hrdata_out <= (ahb_go && !hwrite_in) ? rd_val : 32'h0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			ctrl_rank2_r <= `DDRU_CTRL_RST;
		else if (wr_ph_r && wad_r == `DDRU_OFF_CTRL)
			ctrl_rank2_r <= hwdata_in[`DDRU_CTRL_RANK2];
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!arst_n_in);

	property p_rd_lat;
		(rw_go && is_rd && cl == 5'h4 && !bl8) |=>
			!dq_oe_out [*3] ##1 dq_oe_out [*4] ##1 !dq_oe_out;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read data late");

	property p_self;
		(!ck_en_in[0] && !cs_n_in[0] && cmd == ddru_pkg::DDRU_CMD_REF &&
			pwr_r[0] == ddru_pkg::DDRU_PWR_ACT) |=>
			pwr_r[0] == ddru_pkg::DDRU_PWR_SELF;
	endproperty
	a_self: assert property (p_self) else $error("no self refresh");

	property p_cs;
		(&cs_n_in) |=> $stable(cmd_cnt_r) && $stable(mr_r);
	endproperty
	a_cs: assert property (p_cs) else $error("deselected cmd taken");

	property p_act;
		(go && cmd == ddru_pkg::DDRU_CMD_ACT) |=> open_r[$past(idx)] &&
			row_r[$past(idx)] == $past(addr_in[`DDRU_ROW_W-1:0]);
	endproperty
	a_act: assert property (p_act) else $error("row not opened");

	property p_ap;
		(rw_go && is_rd && addr_in[`DDRU_AP_BIT] && cl == 5'h4 && !bl8) |->
			##8 open_r[$past(idx, 8)] ##1 !open_r[$past(idx, 9)];
	endproperty
	a_ap: assert property (p_ap) else $error("auto precharge off");

	property p_pre_all;
		(go && cmd == ddru_pkg::DDRU_CMD_PRE && addr_in[`DDRU_AP_BIT] &&
			!sel) |=> open_r[3:0] == 4'h0;
	endproperty
	a_pre_all: assert property (p_pre_all) else $error("banks open");

	property p_dm;
		(rw_go && !is_rd && cl == 5'h4) |-> ##3 mem_we && mem_be == ~dm_in;
	endproperty
	a_dm: assert property (p_dm) else $error("write mask wrong");

	property p_rank_cke;
		(ck_en_in[0] && !ck_en_in[1]) |=>
			pwr_r[0] == ddru_pkg::DDRU_PWR_ACT && !odt_on_out[1];
	endproperty
	a_rank_cke: assert property (p_rank_cke) else $error("cke crossed");

	property p_pream;
		$rose(dq_oe_out) |-> $past(dqs_oe_out) && !$past(dqs_out);
	endproperty
	a_pream: assert property (p_pream) else $error("no preamble");

	property p_post;
		$fell(dq_oe_out) |-> dqs_oe_out ##1 !dqs_oe_out;
	endproperty
	a_post: assert property (p_post) else $error("no postamble");

	c_rd_ap: cover property (rw_go && is_rd && addr_in[`DDRU_AP_BIT]);
	c_self: cover property (pwr_r[0] == ddru_pkg::DDRU_PWR_SELF);
	c_mask: cover property (mem_we && dm_in != 8'h0);

endmodule : ddru_top

`default_nettype wire

// >>> verif/ddru_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// memory controller side of the command and data pins
// ----------------------------------------------------------------
module ddru_ctl_model (
	// clock
	input  wire logic        clk_sys_in,
	// command and address
	output logic      [1:0]  cs_n_out,
	output logic             ras_n_out,
	output logic             cas_n_out,
	output logic             we_n_out,
	output logic      [1:0]  ba_out,
	output logic      [13:0] addr_out,
	// data
	output logic      [7:0]  dm_out,
	output logic      [63:0] dq_out,
	input  wire logic [63:0] dq_in,
	input  wire logic        dq_oe_in,
	input  wire logic        dqs_in,
	input  wire logic        dqs_oe_in
);
	logic [2:0] cmd_r;

	assign {ras_n_out, cas_n_out, we_n_out} = cmd_r;

	initial
	begin
		cmd_r    = 3'h7;
		cs_n_out = 2'h3;
		ba_out   = 2'h0;
		addr_out = 14'h0000;
		dm_out   = 8'h00;
		dq_out   = 64'h0;
	end

	// one command, then a quiet gap of 32 cycles (160 ns); the gap is
	// longer than every spacing the controller owes the module
	task automatic issue(
		input  logic [1:0]  cs,
		input  logic [2:0]  c,
		input  logic [1:0]  ba,
		input  logic [13:0] a,
		input  int          wr_at,
		input  int          bl,
		input  logic [63:0] d [8],
		input  logic [7:0]  m [8],
		output logic [63:0] q [8],
		output logic [31:0] oe_t,
		output logic [31:0] soe_t,
		output logic [31:0] dqs_t
	);
		int k;
		int n;
		n = 0;
		@(posedge clk_sys_in);
		cs_n_out <= cs;  // held up to the sampling edge
		cmd_r    <= c;
		ba_out   <= ba;
		addr_out <= a;
		@(posedge clk_sys_in);
		cs_n_out <= 2'h3;
		for (int j = 0; j < 32; j++)
		begin
			// wr_at is the edge after the command that takes beat 0
			k = j + 1 - wr_at;
			cmd_r    <= ~cmd_r;  // junk while deselected
			ba_out   <= ~ba_out;
			addr_out <= ~addr_out;
			if (wr_at >= 0 && k >= 0 && k < bl)
			begin
				dq_out <= d[k];  // one beat per cycle
				dm_out <= m[k];
			end
			else
			begin
				dq_out <= ~dq_out;  // released lines never hold
				dm_out <= ~dm_out;
			end
			@(negedge clk_sys_in);
			oe_t[j]  = dq_oe_in;
			soe_t[j] = dqs_oe_in;
			dqs_t[j] = dqs_in;
			if (dq_oe_in === 1'b1 && n < 8)
			begin
				q[n] = dq_in;
				n++;
			end
			@(posedge clk_sys_in);
		end
	endtask : issue
endmodule : ddru_ctl_model

`default_nettype wire

// >>> verif/ddru_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddru_defs.svh"

module ddru_top_tb;
	logic        clk_sys_in, arst_n_in, hsel, hwrite, hready, hresp;
	logic [1:0]  htrans, ck_en, odt, odt_on, cs_n, ba, bk;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, oe_t, soe_t, dqs_t, r;
	logic        ras_n, cas_n, we_n, dq_oe, dqs, dqs_oe, bt, c3;
	logic [13:0] addr, md, col;
	logic [7:0]  dm;
	logic [63:0] dq_w, dq_r;
	logic [63:0] wd [8];
	logic [7:0]  wm [8];
	logic [63:0] q [8];
	logic [63:0] mem [64];
	int          cl, bl, miscompares, check_count;

	ddru_top i_dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
		.hresp_out(hresp), .ck_en_in(ck_en), .cs_n_in(cs_n),
		.ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .ba_in(ba),
		.addr_in(addr), .odt_in(odt), .dm_in(dm), .dq_in(dq_w),
		.dq_out(dq_r), .dq_oe_out(dq_oe), .dqs_out(dqs),
		.dqs_oe_out(dqs_oe), .odt_on_out(odt_on));

	ddru_ctl_model i_ctl (.clk_sys_in(clk_sys_in), .cs_n_out(cs_n),
		.ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n),
		.ba_out(ba), .addr_out(addr), .dm_out(dm), .dq_out(dq_w),
		.dq_in(dq_r), .dq_oe_in(dq_oe), .dqs_in(dqs), .dqs_oe_in(dqs_oe));

	initial
	begin
		clk_sys_in = 1'b0;
		forever #2.5 clk_sys_in = ~clk_sys_in;  // 5 ns period
	end

	// ----------------------------------------------------------------
	// expectations
	// ----------------------------------------------------------------
	function automatic logic [31:0] win(input int lo, input int n);
		win = ((32'h1 << n) - 32'h1) << lo;
	endfunction : win

	function automatic logic [13:0] mode_val(input int l, input int n,
		input logic t);
		mode_val = {7'h00, 3'(l), t, (n == 8) ? `DDRU_MR_BL8 : 3'h2};
	endfunction : mode_val

	function automatic logic [63:0] merge(input logic [63:0] o, w,
		input logic [7:0] m);
		for (int i = 0; i < 8; i++)
			merge[8*i +: 8] = m[i] ? o[8*i +: 8] : w[8*i +: 8];
	endfunction : merge

	function automatic logic [5:0] idx(input logic [1:0] b,
		input logic [13:0] a, input int k);
		logic [2:0] o;
		// burst order wraps inside the burst: sequential adds, interleave xors
		o = bt ? (a[2:0] ^ 3'(k)) : (a[2:0] + 3'(k));
		idx = (bl == 8) ? {b, a[3], o} : {b, a[3:2], o[1:0]};
	endfunction : idx

	// ----------------------------------------------------------------
	// drivers and checks
	// ----------------------------------------------------------------
	task automatic check(input logic [63:0] got, exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got,
				exp);
		end
	endtask : check

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize

	// each phase is held until ready is seen high at a rising edge; read
	// data is taken at the edge that closes the data phase
	task automatic ahb(input logic w, input logic [31:0] a, d,
		input logic [2:0] sz);
		@(posedge clk_sys_in);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= w;
		hsize  <= sz;
		do @(posedge clk_sys_in); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys_in); while (hready !== 1'b1);
		r = hrdata;
	endtask : ahb

	task automatic expect_reg(input logic [31:0] a, e);
		ahb(1'b0, a, 32'h0, 3'h2);
		check(64'(r), 64'(e), "register");
	endtask : expect_reg

	task automatic cmd(input logic [1:0] s, input logic [2:0] c,
		input logic [1:0] b, input logic [13:0] a, input int wat);
		i_ctl.issue(s, c, b, a, wat, bl, wd, wm, q, oe_t, soe_t, dqs_t);
	endtask : cmd

	task automatic wr_burst(input logic [1:0] b, input logic mk);
		for (int k = 0; k < 8; k++)
		begin
			wd[k] = {$urandom, $urandom};
			wm[k] = mk ? 8'($urandom) : 8'h00;
			if (k < bl)
				mem[idx(b, col, k)] = merge(mem[idx(b, col, k)], wd[k], wm[k]);
		end
		cmd(2'h2, ddru_pkg::DDRU_CMD_WR, b, col, cl - 1);
	endtask : wr_burst

	initial
	begin
		repeat (20000) @(posedge clk_sys_in);
		miscompares++;
		summarize();
	end

	initial
	begin
		void'($urandom(32'hf9a78694));
		{arst_n_in, hsel, htrans, haddr, hwrite, hwdata} = '0;
		{hsize, ck_en, odt} = {3'h2, 2'h3, 2'h0};
		{cl, bl} = {32'd4, 32'd4};
		repeat (5) @(posedge clk_sys_in);
		arst_n_in <= 1'b1;
		expect_reg(`DDRU_OFF_CTRL, 32'h0);
		expect_reg(`DDRU_OFF_STAT, 32'h0);
		expect_reg(`DDRU_OFF_MODE, 32'h0042);
		expect_reg(`DDRU_OFF_CCNT, 32'h0);
		ahb(1'b1, 32'h10, 32'hffff_ffff, 3'h2);
		ahb(1'b1, `DDRU_OFF_CTRL, 32'h1, 3'h0);
		expect_reg(32'h10, 32'h0);
		expect_reg(`DDRU_OFF_CTRL, 32'h0);
		check(64'(hresp), 64'h0, "response");
		$display("test reset done");
		for (int i = 0; i < 6; i++)
		begin
			cl  = 3 + i % 3;
			bl  = (i < 3) ? 4 : 8;
			bt  = 1'($urandom);
			c3  = 1'($urandom);
			bk  = 2'($urandom);
			md  = mode_val(cl, bl, bt);
			col = {4'h0, 6'($urandom), c3, 3'($urandom)};
			cmd(2'h2, ddru_pkg::DDRU_CMD_REF, 2'h0, 14'h0, -1);
			cmd(2'h2, ddru_pkg::DDRU_CMD_MRS, 2'h0, md, -1);
			cmd(2'h2, ddru_pkg::DDRU_CMD_MRS, 2'h1, ~md, -1);
			expect_reg(`DDRU_OFF_MODE, 32'(md));
			cmd(2'h2, ddru_pkg::DDRU_CMD_ACT, bk, 14'($urandom) & 14'h1fff, -1);
			expect_reg(`DDRU_OFF_STAT, 32'h1 << bk);
			wr_burst(bk, 1'b0);
			wr_burst(bk, 1'b1);
			cmd(2'h2, ddru_pkg::DDRU_CMD_RD, bk, col | 14'h0400, -1);
			// sample j of the model stands for the edge j + 1 after the command
			for (int k = 0; k < bl; k++)
				check(q[k], mem[idx(bk, col, k)], "read beat");
			check(64'(oe_t), 64'(win(cl - 1, bl)), "data valid");
			check(64'(soe_t), 64'(win(cl - 2, bl + 2)), "strobe");
			check(64'(dqs_t), 64'(win(cl - 1, bl) &
				(32'h5555_5555 << (cl - 1))), "toggle");
			expect_reg(`DDRU_OFF_STAT, 32'h0);
		end
		$display("test bursts done");
		for (int i = 0; i < 4; i++)
			cmd(2'h2, ddru_pkg::DDRU_CMD_ACT, 2'(i), 14'h0, -1);
		cmd(2'h2, ddru_pkg::DDRU_CMD_PRE, 2'h2, 14'h0, -1);
		expect_reg(`DDRU_OFF_STAT, 32'h0b);
		cmd(2'h2, ddru_pkg::DDRU_CMD_RSV, 2'h0, 14'h0, -1);
		cmd(2'h3, ddru_pkg::DDRU_CMD_PRE, 2'h0, 14'h0400, -1);
		expect_reg(`DDRU_OFF_STAT, 32'h0b);
		cmd(2'h2, ddru_pkg::DDRU_CMD_PRE, 2'h1, 14'h0400, -1);
		expect_reg(`DDRU_OFF_STAT, 32'h0);
		expect_reg(`DDRU_OFF_CCNT, 32'h0000_0031);
		$display("test precharge done");
		cmd(2'h1, ddru_pkg::DDRU_CMD_ACT, 2'h1, 14'h0, -1);
		expect_reg(`DDRU_OFF_STAT, 32'h0);
		ahb(1'b1, `DDRU_OFF_CTRL, 32'h1, 3'h2);
		cmd(2'h1, ddru_pkg::DDRU_CMD_ACT, 2'h1, 14'h0, -1);
		expect_reg(`DDRU_OFF_STAT, 32'h20);
		odt <= 2'h3;
		repeat (3) @(posedge clk_sys_in);
		check(64'(odt_on), 64'h3, "termination");
		ck_en <= 2'h1;
		repeat (3) @(posedge clk_sys_in);
		check(64'(odt_on), 64'h1, "termination");
		expect_reg(`DDRU_OFF_STAT, 32'h420);
		$display("test rank done");
		ck_en <= 2'h3;
		fork
			cmd(2'h2, ddru_pkg::DDRU_CMD_REF, 2'h0, 14'h0, -1);
			begin
				@(posedge clk_sys_in);
				ck_en <= 2'h2;
			end
		join
		expect_reg(`DDRU_OFF_STAT, 32'h320);
		ck_en <= 2'h3;
		repeat (3) @(posedge clk_sys_in);
		expect_reg(`DDRU_OFF_STAT, 32'h20);
		$display("test power done");
		summarize();
	end
endmodule : ddru_top_tb

`default_nettype wire
